// *** inc/ica_consts.vh ***
// What this block does
// - Group occupy limit, bits 7:4, resets 1
// - Audio occupy limit, bits 3:0, resets 1
// - Zero limit: grant held while requested
// - Limit N expires after N grants
// - Group promote limit, bits 7:4, resets 1
// - Select bit 1 registers request first
// - Bit 6 selects SPI request sync
// - Bit 5 selects card reader sync
// - Bit 4 selects SDIO request sync
// - Bit 3 selects IDE request sync
// - Bit 1 selects USB request sync
// - Bit 0 selects LPC bridge sync
// - Bits 7,2 reserved, read back written
// - Per-requester priority bit, high wins
`ifndef ICA_CONSTS_VH
`define ICA_CONSTS_VH
`define ICA_OFS_HOLD      8'h52
`define ICA_OFS_PROMOTE   8'h53
`define ICA_OFS_SYNCSEL   8'h54
`define ICA_OFS_PRIO      8'h50
`define ICA_GRP_HI        7
`define ICA_GRP_LO        4
`define ICA_AUD_HI        3
`define ICA_AUD_LO        0
`define ICA_TIMER_RST     8'h11
`define ICA_SYNC_RST      8'h00
`define ICA_PRIO_RST      8'h00
`define ICA_NREQ          8
`define ICA_AUDIO_IDX     7
`define ICA_SYNC_STAGES   2
`endif

// *** logic/ica_req_sync.v ***
`timescale 1ns/1ps
`default_nettype none
module ica_req_sync (
  input  wire mclk,
  input  wire rst_n,
  input  wire req_raw,
  input  wire sync_sel,
  output wire req_out
);
  reg stage1_r;
  reg stage2_r;

  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      stage1_r <= 1'b0;
      stage2_r <= 1'b0;
    end else begin
      stage1_r <= req_raw;
      stage2_r <= stage1_r;
    end
  end

  // Only the second stage is ever looked at; the raw path exists for low-latency clients.
  assign req_out = sync_sel ? stage2_r : req_raw;
endmodule
`default_nettype wire

// *** logic/ica_internal_bus_arbiter.v ***
`timescale 1ns/1ps
`default_nettype none
`include "ica_consts.vh"
// Requester index: 0 LPC/ISA, 1 USB, 2 spare, 3 IDE, 4 SDIO, 5 card reader,
// 6 SPI, 7 audio controller. Indices 0, 1 and 3..6 line up with the sync-select bits.
module ica_internal_bus_arbiter #(
  parameter NREQ = `ICA_NREQ
) (
  input  wire            mclk,
  input  wire            rst_n,
  input  wire            cfg_wr,
  input  wire            cfg_rd,
  input  wire [7:0]      cfg_addr,
  input  wire [7:0]      cfg_wdata,
  output reg  [7:0]      cfg_rdata,
  input  wire [NREQ-1:0] req,
  output reg  [NREQ-1:0] gnt,
  output reg  [NREQ-1:0] promoted
);
  localparam ST_IDLE = 1'b0;
  localparam ST_OWN  = 1'b1;

  reg  [7:0]      hold_ctrl_r;
  reg  [7:0]      promote_ctrl_r;
  reg  [7:0]      sync_sel_r;
  reg  [7:0]      prio_r;
  reg             state_r;
  reg  [2:0]      owner_r;
  reg  [3:0]      occ_cnt_r;
  reg  [3:0]      wait_cnt_r [0:NREQ-1];
  reg  [NREQ-1:0] req_d_r;
  wire [NREQ-1:0] req_use;
  wire [NREQ-1:0] sel_vec;

  // The spare index and the audio client take no sync path.
  assign sel_vec = {1'b0, sync_sel_r[6:3], 1'b0, sync_sel_r[1:0]};

  genvar gi;
  generate
    for (gi = 0; gi < NREQ; gi = gi + 1) begin : g_req
      ica_req_sync u_sync (
        .mclk     (mclk),
        .rst_n    (rst_n),
        .req_raw  (req[gi]),
        .sync_sel (sel_vec[gi]),
        .req_out  (req_use[gi])
      );
    end
  endgenerate

  // Register port. A read returns the value held before a write in the same
  // cycle, so software that writes and reads back must leave one cycle between.
  // Unmapped offsets are ignored on write and read back as zero.
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      hold_ctrl_r    <= `ICA_TIMER_RST;
      promote_ctrl_r <= `ICA_TIMER_RST;
      sync_sel_r     <= `ICA_SYNC_RST;
      prio_r         <= `ICA_PRIO_RST;
      cfg_rdata      <= 8'h00;
    end else begin
      if (cfg_wr) begin
        case (cfg_addr)
          `ICA_OFS_HOLD:    hold_ctrl_r <= cfg_wdata;
          `ICA_OFS_PROMOTE: promote_ctrl_r <= cfg_wdata;
          `ICA_OFS_SYNCSEL: sync_sel_r <= cfg_wdata;
          `ICA_OFS_PRIO:    prio_r <= cfg_wdata;
          default:          ;
        endcase
      end
      if (cfg_rd) begin
        case (cfg_addr)
          `ICA_OFS_HOLD:    cfg_rdata <= hold_ctrl_r;
          `ICA_OFS_PROMOTE: cfg_rdata <= promote_ctrl_r;
          `ICA_OFS_SYNCSEL: cfg_rdata <= sync_sel_r;
          `ICA_OFS_PRIO:    cfg_rdata <= prio_r;
          default:          cfg_rdata <= 8'h00;
        endcase
      end
    end
  end

  // Limits for the current owner and for each requester.
  function [3:0] occ_lim;
    input [2:0] idx;
    begin
      if (idx == `ICA_AUDIO_IDX)
        occ_lim = hold_ctrl_r[`ICA_AUD_HI:`ICA_AUD_LO];
      else
        occ_lim = hold_ctrl_r[`ICA_GRP_HI:`ICA_GRP_LO];
    end
  endfunction

  function [3:0] pro_lim;
    input [2:0] idx;
    begin
      if (idx == `ICA_AUDIO_IDX)
        pro_lim = promote_ctrl_r[`ICA_AUD_HI:`ICA_AUD_LO];
      else
        pro_lim = promote_ctrl_r[`ICA_GRP_HI:`ICA_GRP_LO];
    end
  endfunction

  // A waiting requester counts grants given to others; reaching its promote
  // limit raises it to high priority until it is served.
  wire [NREQ-1:0] eff_hi;
  genvar gp;
  generate
    for (gp = 0; gp < NREQ; gp = gp + 1) begin : g_pro
      assign eff_hi[gp] = prio_r[gp] | promoted[gp];
    end
  endgenerate

  // Limit and expiry for the current owner. One grant is counted per cycle
  // of ownership, so the count is 1 on the cycle the grant first shows.
  wire [3:0]      cur_lim     = occ_lim(owner_r);
  wire [NREQ-1:0] own_mask    = 8'h01 << owner_r;
  wire            others      = |(req_use & ~own_mask);
  wire            expired     = (cur_lim != 4'h0) && (occ_cnt_r >= cur_lim);

  // The holder is left out of the next arbitration when its limit runs out
  // while others wait. Without this mask the lowest index would win again
  // and a low-index holder could keep the bus for good, which is exactly
  // what the occupy limit exists to stop.
  wire            rotate      = (state_r == ST_OWN) && expired && others;
  wire [NREQ-1:0] req_cand    = rotate ? (req_use & ~own_mask) : req_use;
  wire            release_now = !req_use[owner_r] || rotate;

  // Winner: lowest index among high-priority candidates, else among all.
  // Fixed order by index keeps the selector small; fairness among equals
  // comes only from the occupy and promote limits, so a zero limit on a
  // busy low-index client can starve the others.
  reg [2:0]      win_idx;
  reg            win_any;
  reg [NREQ-1:0] hi_req;
  integer k;
  always @* begin
    win_idx = 3'h0;
    win_any = 1'b0;
    hi_req  = req_cand & eff_hi;
    for (k = NREQ - 1; k >= 0; k = k - 1) begin
      if (hi_req[k]) begin
        win_idx = k[2:0];
        win_any = 1'b1;
      end
    end
    if (!win_any) begin
      for (k = NREQ - 1; k >= 0; k = k - 1) begin
        if (req_cand[k]) begin
          win_idx = k[2:0];
          win_any = 1'b1;
        end
      end
    end
  end

  // A grant event is any cycle on which the grant register takes an owner;
  // the promote counters of the clients still waiting step on it.
  wire            grant_evt   = (state_r == ST_IDLE && win_any) ||
                                (state_r == ST_OWN && release_now && win_any);

  integer j;
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      state_r   <= ST_IDLE;
      owner_r   <= 3'h0;
      occ_cnt_r <= 4'h0;
      gnt       <= {NREQ{1'b0}};
      promoted  <= {NREQ{1'b0}};
      for (j = 0; j < NREQ; j = j + 1)
        wait_cnt_r[j] <= 4'h0;
    end else begin
      case (state_r)
        ST_IDLE: begin
          if (win_any) begin
            state_r   <= ST_OWN;
            owner_r   <= win_idx;
            occ_cnt_r <= 4'h1;
            gnt       <= 8'h01 << win_idx;
          end
        end
        ST_OWN: begin
          if (release_now) begin
            // The candidate set already excludes the holder on expiry.
            if (win_any) begin
              owner_r   <= win_idx;
              occ_cnt_r <= 4'h1;
              gnt       <= 8'h01 << win_idx;
            end else begin
              state_r <= ST_IDLE;
              gnt     <= {NREQ{1'b0}};
            end
          end else if (occ_cnt_r != 4'hF) begin
            occ_cnt_r <= occ_cnt_r + 4'h1;
          end
        end
        default: begin
          state_r <= ST_IDLE;
          gnt     <= {NREQ{1'b0}};
        end
      endcase
      for (j = 0; j < NREQ; j = j + 1) begin
        if (grant_evt && win_idx == j[2:0]) begin
          wait_cnt_r[j] <= 4'h0;
          promoted[j]   <= 1'b0;
        end else if (!req_use[j]) begin
          wait_cnt_r[j] <= 4'h0;
          promoted[j]   <= 1'b0;
        end else if (grant_evt && pro_lim(j[2:0]) != 4'h0) begin
          if (wait_cnt_r[j] + 4'h1 >= pro_lim(j[2:0]))
            promoted[j] <= 1'b1;
          if (wait_cnt_r[j] != 4'hF)
            wait_cnt_r[j] <= wait_cnt_r[j] + 4'h1;
        end
      end
    end
  end
endmodule
`default_nettype wire

// *** tb/ica_chk_asserts.sv ***
`timescale 1ns/1ps
`default_nettype none
module ica_chk (
  input wire logic       mclk,
  input wire logic       rst_n,
  input wire logic       cfg_wr,
  input wire logic       cfg_rd,
  input wire logic [7:0] cfg_addr,
  input wire logic [7:0] cfg_wdata,
  input wire logic [7:0] cfg_rdata,
  input wire logic [7:0] req,
  input wire logic [7:0] gnt
);
  logic [7:0] sync_r;
  logic [3:0] aud_r;
  always_ff @(posedge mclk or negedge rst_n)
    if (!rst_n) {sync_r, aud_r} <= 12'h001;
    else if (cfg_wr && cfg_addr == 8'h54) sync_r <= cfg_wdata;
    else if (cfg_wr && cfg_addr == 8'h52) aud_r <= cfg_wdata[3:0];
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  a_gnt_onehot: assert property ($onehot0(gnt))
    else $error("grant not one-hot");
  a_sync_read: assert property (cfg_rd && cfg_addr == 8'h54
    |=> cfg_rdata == $past(sync_r)) else $error("bad sync readback");
  a_hold_read: assert property (cfg_rd && cfg_addr == 8'h52
    |=> cfg_rdata[3:0] == $past(aud_r)) else $error("bad limit readback");
  a_zero_keeps: assert property (gnt[7] && req[7] && aud_r == 4'h0
    |=> gnt[7]) else $error("zero limit lost grant");
  a_limit_moves: assert property (gnt[7] && aud_r == 4'h1
    && |(req[6:0] & ~sync_r[6:0]) |=> !gnt[7]) else $error("limit ignored");
  a_alone_keeps: assert property (gnt[7] && req == 8'h80
    && $past(req[6:0]) == 7'h0 && $past(req[6:0], 2) == 7'h0 |=> gnt[7])
    else $error("lone holder lost grant");
  a_idle_grant: assert property (gnt == 8'h00 && req == 8'h02 && !sync_r[1]
    && $past(req) == 8'h00 && $past(req, 2) == 8'h00 |=> gnt == 8'h02)
    else $error("raw grant late");
  a_sync_delays: assert property ($rose(req[4]) && sync_r[4]
    && !$past(req[4], 2) |=> !gnt[4] [*2]) else $error("sync stage skipped");
  c_moves: cover property (gnt[7] ##1 gnt[1]);
  c_sync: cover property (sync_r[4] && gnt[4]);
  c_zero: cover property (aud_r == 4'h0 && gnt[7] [*3]);
endmodule
bind ica_internal_bus_arbiter ica_chk u_chk (.*);
`default_nettype wire

// *** tb/ica_req_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module ica_req_model (
  input  wire logic       mclk,
  input  wire logic       rst_n,
  input  wire logic [7:0] want,
  input  wire logic [7:0] drop,
  output var  logic [7:0] req
);
  // Held until the bench ends the transfer, so a withdrawn grant shows re-arbitration.
  always_ff @(posedge mclk or negedge rst_n)
    if (!rst_n) req <= 8'h00;
    else req <= (req | want) & ~drop;
endmodule
`default_nettype wire

// *** tb/ica_internal_bus_arbiter_test.sv ***
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, s) begin cmp_count++; if ((s) !== (e)) begin fail_count++; \
  $display("FAIL %s exp %h got %h", n, e, s); end end
module ica_internal_bus_arbiter_test;
  logic       mclk = 1'b0, rst_n = 1'b0, cfg_wr = 1'b0, cfg_rd = 1'b0;
  logic [7:0] cfg_addr = 8'h00, cfg_wdata = 8'h00, want = 8'h00, drop = 8'h00;
  wire  [7:0] cfg_rdata, req, gnt, promoted;
  int         fail_count = 0, cmp_count = 0, base, n;
  ica_internal_bus_arbiter uut (.*);
  ica_req_model pm (.*);
  initial forever #12.5 mclk = ~mclk;
  task close_out;
    $display("compares %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    repeat (1000) @(posedge mclk);
    fail_count++;
    close_out;
  end
  task wr(input logic [7:0] a, d);
    @(negedge mclk) {cfg_wr, cfg_addr, cfg_wdata} = {1'b1, a, d};
    @(negedge mclk) cfg_wr = 1'b0;
  endtask
  task rd(input logic [7:0] a, e);
    @(negedge mclk) {cfg_rd, cfg_addr} = {1'b1, a};
    @(negedge mclk) cfg_rd = 1'b0;
    @(negedge mclk) `CHK("rdata", e, cfg_rdata)
  endtask
  // Both raised in one cycle, so the grant order comes from index order, limits and priority only.
  task seq(input logic [7:0] w, a, b, input int na, nb);
    @(negedge mclk) want = w;
    @(negedge mclk) want = 8'h00;
    for (int i = 0; i < 20 && gnt === 8'h00; i++) @(negedge mclk);
    for (int i = 0; i < 10; i++) begin
      `CHK("gnt", (i % (na + nb) < na) ? a : b, gnt)
      @(negedge mclk);
    end
    drop = w;
    @(negedge mclk) drop = 8'h00;
    repeat (4) @(negedge mclk);
  endtask
  task lat(input int j, output int k);
    @(negedge mclk) want = 8'h01 << j;
    @(negedge mclk) want = 8'h00;
    for (k = 0; k < 20 && gnt[j] !== 1'b1; k++) @(negedge mclk);
    drop = 8'h01 << j;
    @(negedge mclk) drop = 8'h00;
    repeat (5) @(negedge mclk);
  endtask
  initial begin
    repeat (3) @(posedge mclk);
    @(negedge mclk) rst_n = 1'b1;
    rd(8'h52, 8'h11);
    rd(8'h53, 8'h11);
    rd(8'h54, 8'h00);
    wr(8'h53, 8'hF0);
    rd(8'h53, 8'hF0);
    wr(8'h54, 8'h84);
    rd(8'h54, 8'h84);
    wr(8'h52, 8'h31);
    seq(8'h82, 8'h02, 8'h80, 3, 1);
    wr(8'h50, 8'h80);
    seq(8'h82, 8'h80, 8'h02, 1, 3);
    wr(8'h52, 8'h00);
    seq(8'h82, 8'h80, 8'h02, 10, 0);
    wr(8'h54, 8'h00);
    lat(1, base);
    for (int j = 0; j < 8; j++) begin
      if (j == 2) continue;
      wr(8'h54, 8'h01 << j);
      lat(j, n);
      `CHK("lat", (j == 7) ? base : base + 2, n)
    end
    // Promote limit 1: the waiting client is promoted on the first grant to another.
    wr(8'h50, 8'h00);
    wr(8'h52, 8'h11);
    wr(8'h53, 8'h11);
    @(negedge mclk) want = 8'h82;
    @(negedge mclk) want = 8'h00;
    for (int i = 0; i < 20 && gnt === 8'h00; i++) @(negedge mclk);
    `CHK("gnt", 8'h02, gnt)
    `CHK("promoted", 8'h80, promoted)
    @(negedge mclk) `CHK("promoted", 8'h02, promoted)
    `CHK("gnt", 8'h80, gnt)
    close_out;
  end
endmodule
`default_nettype wire
